/* link_fabric_load_init.sv */
/*
 * Start-up and fabric-load controller beside the embedded link core:
 * holds the core in reset under the host's link reset, latches the two
 * mode bits from the standard configuration pass, answers configuration
 * requests with retry or acceptance, forwards image words to the fabric
 * programmer and freezes I/O and spare transceivers while loading.
 * Assumes link status, request strobes and fabric-done are synchronous.
 */
// Behaviour
// - link core and I/O ready under 95 ms (code only flags init_overrun; start-up goes on)
// - core held in reset under link reset
// - fabric programming starts only after L0
// - retry status until user mode unless loading
// - retry period capped at one second (code only flags crs_overrun; retries go on)
// - one endpoint core alone loads fabric
// - general I/O weak high while loading
// - spare transceivers held in reset while loading
// - link loading (mode 10): accept, no retry status
// - mode 01 disables link loading
// - mode 10 loads fabric over link
// - mode 11 standard load, link updates allowed
// - x1 to x8, gen one or two
// - mode bits latched after standard configuration
// - core trains first; loading only after L0
// - cold reset keeps the fabric image
`timescale 1ns/10ps
`include "link_fabric_regs.svh"

module link_fabric_load_init
#(
    parameter int INIT_CYCLES    = `LFL_INIT_CYCLES,
    parameter int CRS_CYCLES     = `LFL_CRS_CYCLES,
    parameter bit IS_LOADER_CORE = 1'b1
)
(
    input  wire logic                    clock,
    input  wire logic                    rstn,
    input  wire logic                    perst_n,
    input  wire logic                    periph_cfg_done,
    input  wire logic [1:0]              mode_bits,
    input  wire logic                    is_endpoint,
    input  wire logic                    link_l0,
    input  wire logic [3:0]              link_lanes,
    input  wire logic [1:0]              link_gen,
    input  wire logic                    cfg_req,
    input  wire logic                    load_valid,
    input  wire logic [`LFL_DATA_W-1:0]  load_data,
    input  wire logic                    fabric_done,
    input  wire logic                    update_req,
    output logic                         load_ready,
    output logic                         link_core_hold,
    output logic                         cfg_crs,
    output logic                         cfg_accept,
    output logic                         fabric_start,
    output logic                         fabric_valid,
    output logic [`LFL_DATA_W-1:0]       fabric_data,
    output logic                         io_weak_high,
    output logic                         xcvr_hold,
    output logic                         user_mode,
    output logic                         link_loading,
    output logic                         mode_error,
    output logic                         init_overrun,
    output logic                         crs_overrun
);
    import link_fabric_pkg::*;

    link_fabric_pkg::ctrl_s s;
    link_fabric_pkg::ctrl_s next_s;
    logic [1:0]             rst_sync;
    logic                   srstn;
    logic                   loader_ok;
    logic                   in_link;
    logic                   init_expired;
    logic                   crs_expired;
    logic                   crs_run;
    logic                   to_link;

    if (INIT_CYCLES < 1 || CRS_CYCLES < 1)
    begin : g_bad_limits
        $error("link_fabric_load_init: time limits must be positive");
    end

    ////////////////////////////////////////////////////////////////////////
    // reset release

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            rst_sync <= 2'h0;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end

    assign srstn = rst_sync[1];

    ////////////////////////////////////////////////////////////////////////
    // link capability

    function automatic logic link_shape_ok(input logic [3:0] lanes, input logic [1:0] gen);
        logic lanes_ok;
        lanes_ok = (lanes == `LFL_LANES_X1) || (lanes == `LFL_LANES_X2) ||
                   (lanes == `LFL_LANES_X4) || (lanes == `LFL_LANES_X8);
        return lanes_ok && ((gen == `LFL_GEN_1) || (gen == `LFL_GEN_2));
    endfunction

    // only the designated endpoint core may carry an image
    assign loader_ok = IS_LOADER_CORE && is_endpoint &&
                       link_shape_ok(link_lanes, link_gen);
    assign in_link   = perst_n && link_l0;
    // mode 11 has its fabric from the standard pass; only mode 10 loads here
    assign to_link   = s.en && !s.full && loader_ok;

    ////////////////////////////////////////////////////////////////////////
    // watchdogs

    // the retry window runs at L0 in the training and standard-load states
    assign crs_run = in_link && (s.state == ST_TRAIN || s.state == ST_STD_LOAD);

    load_timer #(.LIMIT(INIT_CYCLES)) init_timer
    (
        .clock   (clock),
        .srstn   (srstn),
        .run     (s.state == ST_PERIPH),
        .clear   (1'b0),
        .expired (init_expired)
    );

    load_timer #(.LIMIT(CRS_CYCLES)) crs_timer
    (
        .clock   (clock),
        .srstn   (srstn),
        .run     (crs_run),
        .clear   (s.state == ST_USER),
        .expired (crs_expired)
    );

    ////////////////////////////////////////////////////////////////////////
    // control

    always_comb
    begin
        next_s = s;
        next_s.start = 1'b0;
        next_s.fvalid = 1'b0;
        next_s.accept = 1'b0;
        next_s.crs = 1'b0;
        if (init_expired && s.state == ST_PERIPH)
            next_s.init_over = 1'b1;
        if (crs_expired)
            next_s.crs_over = 1'b1;
        case (s.state)
            ST_PERIPH:
            begin
                if (periph_cfg_done)
                begin
                    next_s.en = mode_bits[`LFL_MODE_EN_BIT];
                    next_s.full = mode_bits[`LFL_MODE_FULL_BIT];
                    if (mode_bits == `LFL_MODE_NONE)
                        next_s.state = ST_HALT;
                    else
                        next_s.state = ST_TRAIN;
                end
            end
            ST_TRAIN:
            begin
                // fabric work waits for L0 whatever the mode
                if (in_link)
                begin
                    if (s.loaded)
                        next_s.state = ST_USER;
                    else if (to_link)
                    begin
                        next_s.state = ST_LINK_LOAD;
                        next_s.start = 1'b1;
                    end
                    else
                    begin
                        next_s.state = ST_STD_LOAD;
                        next_s.start = 1'b1;
                    end
                end
            end
            ST_STD_LOAD:
            begin
                if (!perst_n)
                    next_s.state = ST_TRAIN;
                else if (fabric_done)
                begin
                    next_s.state = ST_USER;
                    next_s.loaded = 1'b1;
                end
            end
            ST_LINK_LOAD:
            begin
                if (!in_link)
                    next_s.state = ST_TRAIN;
                else if (fabric_done)
                begin
                    next_s.state = ST_USER;
                    next_s.loaded = 1'b1;
                end
                else
                begin
                    next_s.fvalid = load_valid;
                    next_s.fdata = load_data;
                end
            end
            ST_USER:
            begin
                // link reset leaves the image alone; updates need the enable bit
                if (update_req && in_link && s.en && loader_ok)
                begin
                    next_s.state = ST_LINK_LOAD;
                    next_s.start = 1'b1;
                end
            end
            ST_HALT:
            begin
                next_s.state = ST_HALT;
            end
            default:
            begin
                next_s.state = ST_HALT;
            end
        endcase
        if (cfg_req && in_link)
        begin
            // a core about to load, or holding a loaded image, never retries
            if (s.state == ST_USER || s.state == ST_LINK_LOAD || s.loaded ||
                (s.state == ST_TRAIN && to_link))
                next_s.accept = 1'b1;
            else if (s.state == ST_TRAIN || s.state == ST_STD_LOAD)
                next_s.crs = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge srstn)
    begin
        if (!srstn)
            s <= '0;
        else
            s <= next_s;
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign link_loading   = (s.state == ST_LINK_LOAD);
    assign load_ready     = link_loading && in_link;
    assign link_core_hold = !perst_n || (s.state == ST_PERIPH);
    assign io_weak_high   = link_loading;
    assign xcvr_hold      = link_loading;
    assign user_mode      = (s.state == ST_USER);
    assign mode_error     = (s.state == ST_HALT);
    assign cfg_crs        = s.crs;
    assign cfg_accept     = s.accept;
    assign fabric_start   = s.start;
    assign fabric_valid   = s.fvalid;
    assign fabric_data    = s.fdata;
    assign init_overrun   = s.init_over;
    assign crs_overrun    = s.crs_over;

    ////////////////////////////////////////////////////////////////////////
    // checks

    sequence s_load_begin;
        s.state == ST_TRAIN && in_link && !s.loaded && to_link;
    endsequence

    sequence s_load_entered;
        fabric_start && link_loading;
    endsequence

    property p_core_hold;
        @(posedge clock) disable iff (!srstn)
        !perst_n |-> link_core_hold;
    endproperty
    a_core_hold: assert property (p_core_hold) else $error("core not held in reset");

    property p_start_after_l0;
        @(posedge clock) disable iff (!srstn)
        $rose(fabric_start) |-> $past(link_l0) && $past(perst_n);
    endproperty
    a_start_after_l0: assert property (p_start_after_l0) else $error("load before L0");

    property p_link_load_entry;
        @(posedge clock) disable iff (!srstn)
        s_load_begin |=> s_load_entered;
    endproperty
    a_link_load_entry: assert property (p_link_load_entry) else $error("no link load");

    property p_retry;
        @(posedge clock) disable iff (!srstn)
        cfg_req && in_link && !s.loaded &&
            (s.state == ST_STD_LOAD || (s.state == ST_TRAIN && !to_link))
            |=> cfg_crs && !cfg_accept;
    endproperty
    a_retry: assert property (p_retry) else $error("retry status missing");

    property p_accept;
        @(posedge clock) disable iff (!srstn)
        cfg_req && in_link && link_loading |=> cfg_accept && !cfg_crs;
    endproperty
    a_accept: assert property (p_accept) else $error("loading request not accepted");

    property p_freeze;
        @(posedge clock) disable iff (!srstn)
        link_loading |-> io_weak_high && xcvr_hold;
    endproperty
    a_freeze: assert property (p_freeze) else $error("I/O not frozen");

    property p_loader_core;
        @(posedge clock) disable iff (!srstn)
        $rose(link_loading) |-> $past(is_endpoint) && IS_LOADER_CORE;
    endproperty
    a_loader_core: assert property (p_loader_core) else $error("bad loader core");

    property p_no_link_mode01;
        @(posedge clock) disable iff (!srstn)
        !s.en |-> !link_loading;
    endproperty
    a_no_link_mode01: assert property (p_no_link_mode01) else $error("link load disabled");

    property p_mode00;
        @(posedge clock) disable iff (!srstn)
        s.state == ST_PERIPH && periph_cfg_done && mode_bits == `LFL_MODE_NONE
            |=> mode_error [*2];
    endproperty
    a_mode00: assert property (p_mode00) else $error("mode 00 accepted");

    property p_cold_reset;
        @(posedge clock) disable iff (!srstn)
        user_mode && !perst_n |=> user_mode && !fabric_start;
    endproperty
    a_cold_reset: assert property (p_cold_reset) else $error("cold reset reloaded");

    property p_crs_limit;
        @(posedge clock) disable iff (!srstn)
        crs_expired |=> crs_overrun;
    endproperty
    a_crs_limit: assert property (p_crs_limit) else $error("retry overrun missed");
endmodule

/* link_fabric_regs.svh */
/*
 * Named constants for the fabric load and start-up controller: mode
 * encodings, link limits, clock rate and time limits.
 * Assumes inclusion by bare name from package and modules alike.
 */
`ifndef LINK_FABRIC_REGS_SVH
`define LINK_FABRIC_REGS_SVH

`define LFL_DATA_W          32
`define LFL_CLK_HZ          20000000
`define LFL_INIT_LIMIT_MS   95
`define LFL_CRS_LIMIT_S     1
`define LFL_INIT_CYCLES     (`LFL_INIT_LIMIT_MS * (`LFL_CLK_HZ / 1000))
`define LFL_CRS_CYCLES      (`LFL_CRS_LIMIT_S * `LFL_CLK_HZ)

// mode bits: [1] loading enable, [0] whole-device initialization
`define LFL_MODE_NONE       2'h0
`define LFL_MODE_EN_BIT     1
`define LFL_MODE_FULL_BIT   0

`define LFL_LANES_X1        4'h1
`define LFL_LANES_X2        4'h2
`define LFL_LANES_X4        4'h4
`define LFL_LANES_X8        4'h8
`define LFL_GEN_1           2'h1
`define LFL_GEN_2           2'h2

`endif

/* link_fabric_pkg.sv */
/*
 * Types for the fabric load and start-up controller: state encoding and
 * the packed state record of the controller.
 * Assumes link_fabric_regs.svh is on the include path.
 */
`include "link_fabric_regs.svh"

package link_fabric_pkg;

    typedef enum logic [2:0]
    {
        ST_PERIPH    = 3'b000,
        ST_TRAIN     = 3'b001,
        ST_STD_LOAD  = 3'b010,
        ST_LINK_LOAD = 3'b011,
        ST_USER      = 3'b100,
        ST_HALT      = 3'b101
    } load_state_e;

    typedef struct packed
    {
        load_state_e             state;
        logic                    en;
        logic                    full;
        logic                    loaded;
        logic                    start;
        logic                    fvalid;
        logic [`LFL_DATA_W-1:0]  fdata;
        logic                    crs;
        logic                    accept;
        logic                    init_over;
        logic                    crs_over;
    } ctrl_s;

endpackage

/* load_timer.sv */
/*
 * Elapsed-time watchdog: counts clock cycles while run is high, flags
 * expiry once LIMIT cycles have passed, and restarts when clear is high.
 * Assumes a synchronously released active-low reset from its parent.
 */
`timescale 1ns/10ps

module load_timer
#(
    parameter int LIMIT = 1900000
)
(
    input  wire logic clock,
    input  wire logic srstn,
    input  wire logic run,
    input  wire logic clear,
    output logic      expired
);
    localparam int CW = $clog2(LIMIT + 1);

    typedef struct packed
    {
        logic [CW-1:0] count;
        logic          expired;
    } timer_s;

    timer_s s;
    timer_s next_s;

    // refused while elaborating, before any cycle is counted
    if (LIMIT < 1)
    begin : g_bad_limit
        $error("load_timer: LIMIT must be at least one cycle");
    end

    always_comb
    begin
        next_s = s;
        if (clear)
        begin
            next_s.count = '0;
            next_s.expired = 1'b0;
        end
        else if (run && !s.expired)
        begin
            next_s.count = s.count + 1'b1;
            // expiry latches; the count then stops
            if (s.count == CW'(LIMIT - 1))
                next_s.expired = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge srstn)
    begin
        if (!srstn)
            s <= '0;
        else
            s <= next_s;
    end

    assign expired = s.expired;
endmodule

/* host_link_model.sv */
/*
 * Host root port model: drives link reset, link training state, config
 * polling and image words toward the fabric load controller.
 * Assumes bench commands change at the falling clock edge.
 */
`timescale 1ns/10ps

module host_link_model
(
    input  wire logic        clock,
    input  wire logic        perst_cmd,
    input  wire logic        link_cmd,
    input  wire logic        poll_cmd,
    input  wire logic        load_go,
    input  wire logic        load_ready,
    output logic             perst_n,
    output logic             link_l0,
    output logic             cfg_req,
    output logic             load_valid,
    output logic [31:0]      load_data
);
    int   sent = 0;
    int   tick = 0;
    logic took = 1'b0;
    logic perst_q = 1'b0;
    logic link_q = 1'b0;
    logic poll_q = 1'b0;
    logic go_q = 1'b0;

    initial
    begin
        perst_n = 1'b0;
        link_l0 = 1'b0;
        cfg_req = 1'b0;
        load_valid = 1'b0;
        load_data = 32'h0;
    end

    // commands are picked up at the rising edge so that the bench's
    // falling-edge writes never race the falling-edge drive below
    always @(posedge clock)
    begin
        took <= load_valid && load_ready;
        perst_q <= perst_cmd;
        link_q <= link_cmd;
        poll_q <= poll_cmd;
        go_q <= load_go;
    end

    ////////////////////////////////////////////////////////////////////
    always @(negedge clock)
    begin
        perst_n <= perst_q;
        // link only trains once the reset is released
        link_l0 <= perst_q && perst_n && link_q;
        tick <= tick + 1;
        // keep polling while retries come back
        cfg_req <= poll_q && link_l0 && (tick[1:0] == 2'h0);
        if (!go_q)
            sent <= 0;
        else if (took)
            sent <= sent + 1;
        if (go_q && load_ready && (sent + took) < 6)
        begin
            load_valid <= 1'b1;
            load_data <= 32'h5a00_0000 + 32'(sent + took);
        end
        else
        begin
            load_valid <= 1'b0;
            // released bus must not keep the last word
            load_data <= ~load_data;
        end
    end
endmodule

/* test_link_fabric_load_init.sv */
/*
 * Self-checking bench for the fabric load controller, host model on the
 * link side. Assumes short timer limits so overruns are reached quickly.
 */
`timescale 1ns/10ps

module test_link_fabric_load_init;
    logic        clock, rstn, periph_cfg_done, is_endpoint, fabric_done, update_req;
    logic [1:0]  mode_bits, link_gen;
    logic [3:0]  link_lanes;
    logic        perst_cmd, link_cmd, poll_cmd, load_go;
    logic        perst_n, link_l0, cfg_req, load_valid, load_ready, link_core_hold;
    logic        cfg_crs, cfg_accept, fabric_start, fabric_valid, io_weak_high;
    logic        xcvr_hold, user_mode, link_loading, mode_error, init_overrun;
    logic        crs_overrun;
    logic [31:0] load_data, fabric_data;
    int          errors = 0;
    int          total_checks = 0;
    int          starts, crs, acc, words;

    link_fabric_load_init #(.INIT_CYCLES(20), .CRS_CYCLES(40), .IS_LOADER_CORE(1'b1))
    i_link_fabric_load_init
    (
        .clock, .rstn, .perst_n, .periph_cfg_done, .mode_bits, .is_endpoint,
        .link_l0, .link_lanes, .link_gen, .cfg_req, .load_valid, .load_data,
        .fabric_done, .update_req, .load_ready, .link_core_hold, .cfg_crs,
        .cfg_accept, .fabric_start, .fabric_valid, .fabric_data, .io_weak_high,
        .xcvr_hold, .user_mode, .link_loading, .mode_error, .init_overrun,
        .crs_overrun
    );

    host_link_model i_host_link_model
    (
        .clock, .perst_cmd, .link_cmd, .poll_cmd, .load_go, .load_ready,
        .perst_n, .link_l0, .cfg_req, .load_valid, .load_data
    );

    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] want);
        total_checks++;
        if (seen !== want)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", what, want, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    always @(posedge clock)
    begin
        if (fabric_start)
            starts++;
        if (cfg_crs)
            crs++;
        if (cfg_accept)
            acc++;
        if (fabric_valid)
        begin
            chk("fabric_data", fabric_data, 32'h5a00_0000 + words);
            words++;
        end
    end

    // reset, then the standard pass hands over the mode bits
    task automatic boot(input logic [1:0] mode, input int wait_n);
        rstn = 1'b0;
        perst_cmd = 1'b0;
        link_cmd = 1'b0;
        poll_cmd = 1'b0;
        load_go = 1'b0;
        fabric_done = 1'b0;
        update_req = 1'b0;
        mode_bits = mode;
        cyc(3);
        rstn = 1'b1;
        cyc(wait_n);
        periph_cfg_done = 1'b1;
        cyc(1);
        periph_cfg_done = 1'b0;
        cyc(1);
        chk("hold_perst", link_core_hold, 1);
        perst_cmd = 1'b1;
        cyc(2);
        starts = 0;
        crs = 0;
        acc = 0;
        words = 0;
    endtask

    task automatic link_up;
        chk("hold_released", link_core_hold, 0);
        cyc(4);
        chk("start_before_l0", starts, 0);
        link_cmd = 1'b1;
        cyc(3);
        chk("start_after_l0", starts, 1);
    endtask

    task automatic pulse_done;
        fabric_done = 1'b1;
        cyc(1);
        fabric_done = 1'b0;
        cyc(1);
    endtask

    task automatic pulse_update;
        update_req = 1'b1;
        cyc(1);
        update_req = 1'b0;
        cyc(2);
    endtask

    ////////////////////////////////////////////////////////////////////
    task automatic t_link_load;
        boot(2'b10, 4);
        // bits changed after the standard pass must be ignored
        mode_bits = 2'b01;
        link_up();
        chk("loading", link_loading, 1);
        chk("io_weak", io_weak_high, 1);
        chk("xcvr_hold", xcvr_hold, 1);
        poll_cmd = 1'b1;
        load_go = 1'b1;
        cyc(16);
        chk("crs_count", crs, 0);
        chk("accept_seen", acc > 0, 1);
        chk("word_count", words, 6);
        poll_cmd = 1'b0;
        load_go = 1'b0;
        pulse_done();
        chk("user", user_mode, 1);
        chk("io_free", io_weak_high, 0);
        chk("xcvr_free", xcvr_hold, 0);
        perst_cmd = 1'b0;
        cyc(3);
        chk("cold_hold", link_core_hold, 1);
        perst_cmd = 1'b1;
        cyc(6);
        chk("cold_user", user_mode, 1);
        chk("cold_starts", starts, 1);
        $display("link load test done");
    endtask

    task automatic t_std;
        boot(2'b01, 4);
        link_up();
        chk("no_loading", link_loading, 0);
        chk("ready_off", load_ready, 0);
        poll_cmd = 1'b1;
        cyc(16);
        chk("crs_seen", crs > 0, 1);
        chk("no_accept", acc, 0);
        chk("crs_in_time", crs_overrun, 0);
        cyc(30);
        chk("crs_late", crs_overrun, 1);
        pulse_done();
        cyc(8);
        chk("user_accept", acc > 0, 1);
        pulse_update();
        chk("no_update", starts, 1);
        chk("stays_user", user_mode, 1);
        $display("standard load test done");
    endtask

    task automatic t_full;
        boot(2'b11, 4);
        link_up();
        chk("full_no_loading", link_loading, 0);
        pulse_done();
        chk("full_user", user_mode, 1);
        pulse_update();
        chk("update_start", starts, 2);
        chk("update_loading", link_loading, 1);
        $display("full init test done");
    endtask

    task automatic t_err;
        boot(2'b00, 4);
        chk("mode_bad", mode_error, 1);
        chk("init_ok", init_overrun, 0);
        boot(2'b01, 26);
        chk("init_late", init_overrun, 1);
        chk("mode_ok", mode_error, 0);
        $display("error test done");
    endtask

    task automatic t_lanes;
        logic [3:0] ln [6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'h4};
        logic [1:0] gn [6] = '{2'h1, 2'h2, 2'h2, 2'h1, 2'h1, 2'h2};
        logic       ok [6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
        for (int i = 0; i < 6; i++)
        begin
            link_lanes = ln[i];
            link_gen = gn[i];
            is_endpoint = (i != 5);
            boot(2'b10, 4);
            link_up();
            chk("lane_loading", link_loading, ok[i]);
        end
        $display("lane test done");
    endtask

    initial
    begin
        rstn = 1'b0;
        periph_cfg_done = 1'b0;
        mode_bits = 2'b10;
        is_endpoint = 1'b1;
        link_lanes = 4'h4;
        link_gen = 2'h1;
        fabric_done = 1'b0;
        update_req = 1'b0;
        perst_cmd = 1'b0;
        link_cmd = 1'b0;
        poll_cmd = 1'b0;
        load_go = 1'b0;
        t_link_load();
        t_std();
        t_full();
        t_err();
        t_lanes();
        close_out();
    end

    // whole run is well under 1000 cycles
    initial
    begin
        #(50 * 5000);
        errors++;
        close_out();
    end
endmodule
